/* File: src/edpr_defines.svh */
// Constants of the embedded dual-port RAM block: capacities, widths, read latency, reset values.
// Assumes inclusion by every file that sizes storage or checks a shape.
`ifndef EDPR_DEFINES_SVH
`define EDPR_DEFINES_SVH

// Storage capacity in bits, plain and with parity
`define EDPR_SMALL_BITS        576
`define EDPR_SMALL_DATA_BITS   512
`define EDPR_MEDIUM_BITS       4608
`define EDPR_MEDIUM_DATA_BITS  4096
`define EDPR_LARGE_BITS        589824
`define EDPR_LARGE_DATA_BITS   524288

// Widest port of each size, and narrowest port of the large size
`define EDPR_SMALL_MAX_W       16
`define EDPR_MEDIUM_MAX_W      36
`define EDPR_LARGE_MAX_W       144
`define EDPR_LARGE_MIN_W       8

// Width of one parity-bearing byte lane
`define EDPR_PARITY_LANE       9

// Cycles from registered read address to stored read word
`define EDPR_READ_LATENCY      1

// Reset value of every single-bit register except the queue empty flag
`define EDPR_CLEAR_VAL         1'h0

// Reset value of the queue empty flag
`define EDPR_EMPTY_VAL         1'h1

`endif

/* File: src/edpr_pkg.sv */
// Types shared by the embedded dual-port RAM block.
// Assumes nothing beyond a SystemVerilog compiler.
package edpr_pkg;

	typedef enum logic [1:0] {
		EDPR_SMALL,
		EDPR_MEDIUM,
		EDPR_LARGE
	} edpr_size_e;

	typedef enum logic [2:0] {
		EDPR_SIMPLE_DP,
		EDPR_SINGLE_PORT,
		EDPR_TRUE_DP,
		EDPR_ROM,
		EDPR_FIFO,
		EDPR_SHIFT
	} edpr_mode_e;

	typedef struct packed {
		edpr_mode_e mode;
		logic       out_bypass;
	} edpr_cfg_s;

endpackage

/* File: src/edpr_store.sv */
// Storage array of the embedded dual-port RAM block with two mixed-width ports.
// Assumes registered addresses and strobes from the top; widths differ by a power of two.
`timescale 1ns/1ps
`include "edpr_defines.svh"

module edpr_store #(
	parameter int                          A_WIDTH    = 16,
	parameter int                          B_WIDTH    = 16,
	parameter int                          A_DEPTH    = 32,
	parameter int                          B_DEPTH    = A_WIDTH * A_DEPTH / B_WIDTH,
	parameter bit                          INIT_EN    = 1'b1,
	parameter logic [A_WIDTH*A_DEPTH-1:0]  INIT_IMAGE = '0
) (
	input  wire logic                          clk,
	input  wire logic                          reset_n,
	input  wire logic                          a_we,
	input  wire logic                          a_re,
	input  wire logic [$clog2(A_DEPTH)-1:0]    a_addr,
	input  wire logic [A_WIDTH-1:0]            a_wdata,
	input  wire logic                          b_we,
	input  wire logic                          b_re,
	input  wire logic [$clog2(B_DEPTH)-1:0]    b_addr,
	input  wire logic [B_WIDTH-1:0]            b_wdata,
	output logic      [A_WIDTH-1:0]            a_raw_ff,
	output logic      [B_WIDTH-1:0]            b_raw_ff
);

	localparam int LW    = (A_WIDTH < B_WIDTH) ? A_WIDTH : B_WIDTH;
	localparam int LANES = A_WIDTH * A_DEPTH / LW;
	localparam int RA    = A_WIDTH / LW;
	localparam int RB    = B_WIDTH / LW;

	typedef logic [LW-1:0] edpr_mem_t [LANES];

	// Preload image; the large size powers up undefined
	function automatic edpr_mem_t preload();
		edpr_mem_t img;
		for (int i = 0; i < LANES; i++) begin
			if (INIT_EN) begin
				img[i] = INIT_IMAGE[i*LW +: LW];
			end
		end
		return img;
	endfunction

	edpr_mem_t          mem = preload();
	logic [A_WIDTH-1:0] a_rd;
	logic [B_WIDTH-1:0] b_rd;

	// Gather read lanes for each port
	for (genvar j = 0; j < RA; j++) begin : g_a_lane
		assign a_rd[j*LW +: LW] = mem[int'(a_addr) * RA + j];
	end
	for (genvar j = 0; j < RB; j++) begin : g_b_lane
		assign b_rd[j*LW +: LW] = mem[int'(b_addr) * RB + j];
	end

	// Port A write is applied last and wins a same-lane collision
	always_ff @(posedge clk) begin
		if (b_we) begin
			for (int j = 0; j < RB; j++) begin
				mem[int'(b_addr) * RB + j] <= b_wdata[j*LW +: LW];
			end
		end
		if (a_we) begin
			for (int j = 0; j < RA; j++) begin
				mem[int'(a_addr) * RA + j] <= a_wdata[j*LW +: LW];
			end
		end
	end

	// Read word one clock after the address register, old data on collision
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			a_raw_ff <= '0;
			b_raw_ff <= '0;
		end else begin
			if (a_re) begin
				a_raw_ff <= a_rd;
			end
			if (b_re) begin
				b_raw_ff <= b_rd;
			end
		end
	end

endmodule

/* File: src/edpr_top.sv */
// Embedded dual-port RAM block: input registers, mode steering, output registers.
// Assumes user fabric logic on clk; both block clocks are the same clk here.
//
// Summary of operation
// - The small block holds 576 bits, parity bits included.
// - The small block takes the shapes 512x1, 256x2, 128x4, 64x8, 64x9 and 32x16.
// - The medium block takes 4Kx1, 2Kx2, 1Kx4, 512x8, 512x9, 256x16, 256x18, 128x32, 128x36.
// - The large block takes 64Kx8 through 4Kx144 in the listed pairs of depth and width.
// - Clearing the input registers zeroes them at once; the stored read word keeps its value.
// - Clearing the output registers zeroes them and shows on the outputs at once unless the output register is bypassed.
// - The small block offers simple dual-port, single-port, FIFO, ROM and shift modes only.
// - Write strobe, write data and write address registers share one clock.
// - Read address, read strobe and output registers may use either block clock.
// - Only the output register can be bypassed; input registers stay in the path.
// - Small and medium storage accepts a preload image in RAM or ROM use.
// - A read of an address written by the other port in that cycle returns old data.
// - Mixed port widths are allowed in simple dual-port mode; in true dual-port only when not small.
// - Large storage is not preloaded and starts undefined.
`timescale 1ns/1ps
`include "edpr_defines.svh"

module edpr_top #(
	parameter edpr_pkg::edpr_size_e        BLOCK_SIZE = edpr_pkg::EDPR_SMALL,
	parameter int                          A_WIDTH    = 16,
	parameter int                          B_WIDTH    = 16,
	parameter int                          A_DEPTH    = 32,
	parameter logic [A_WIDTH*A_DEPTH-1:0]  INIT_IMAGE = '0
) (
	input  wire logic                                   clk,
	input  wire logic                                   reset_n,
	input  wire logic                                   in_aclr,
	input  wire logic                                   out_aclr,
	input  wire edpr_pkg::edpr_cfg_s                    cfg,
	input  wire logic                                   a_wren,
	input  wire logic                                   a_rden,
	input  wire logic [$clog2(A_DEPTH)-1:0]             a_addr,
	input  wire logic [A_WIDTH-1:0]                     a_data,
	input  wire logic                                   b_wren,
	input  wire logic                                   b_rden,
	input  wire logic [$clog2(A_WIDTH*A_DEPTH/B_WIDTH)-1:0] b_addr,
	input  wire logic [B_WIDTH-1:0]                     b_data,
	output logic      [A_WIDTH-1:0]                     a_q,
	output logic      [B_WIDTH-1:0]                     b_q,
	output logic                                        fifo_full_ff,
	output logic                                        fifo_empty_ff,
	output logic                                        cfg_legal_ff
);

	localparam int B_DEPTH = A_WIDTH * A_DEPTH / B_WIDTH;
	localparam int AAW     = $clog2(A_DEPTH);
	localparam int BAW     = $clog2(B_DEPTH);
	localparam int CW      = AAW + 1;

	// Shape check of one port against the size's width list and capacity
	function automatic bit shape_ok(input int w, input int d);
		bit par;
		bit pow;
		int cap;
		int dcap;
		int maxw;
		int minw;
		par  = (w % `EDPR_PARITY_LANE == 0) && ((w / `EDPR_PARITY_LANE) & (w / `EDPR_PARITY_LANE - 1)) == 0;
		pow  = (w > 0) && ((w & (w - 1)) == 0);
		cap  = `EDPR_SMALL_BITS;
		dcap = `EDPR_SMALL_DATA_BITS;
		maxw = `EDPR_SMALL_MAX_W;
		minw = 1;
		unique case (BLOCK_SIZE)
			edpr_pkg::EDPR_SMALL: begin
				cap  = `EDPR_SMALL_BITS;
				dcap = `EDPR_SMALL_DATA_BITS;
				maxw = `EDPR_SMALL_MAX_W;
				par  = par && (w == `EDPR_PARITY_LANE);
			end
			edpr_pkg::EDPR_MEDIUM: begin
				cap  = `EDPR_MEDIUM_BITS;
				dcap = `EDPR_MEDIUM_DATA_BITS;
				maxw = `EDPR_MEDIUM_MAX_W;
			end
			edpr_pkg::EDPR_LARGE: begin
				cap  = `EDPR_LARGE_BITS;
				dcap = `EDPR_LARGE_DATA_BITS;
				maxw = `EDPR_LARGE_MAX_W;
				minw = `EDPR_LARGE_MIN_W;
			end
		endcase
		return (w <= maxw) && (w >= minw) &&
			((pow && w * d == dcap) || (par && w * d == cap));
	endfunction

	localparam bit SHAPE_OK = shape_ok(A_WIDTH, A_DEPTH) && shape_ok(B_WIDTH, B_DEPTH);
	localparam bit MIXED    = (A_WIDTH != B_WIDTH);
	localparam bit INIT_EN  = (BLOCK_SIZE != edpr_pkg::EDPR_LARGE);

	// Input registers; none of them can be bypassed
	logic               a_we_ff;
	logic               a_re_ff;
	logic [AAW-1:0]     a_addr_ff;
	logic [A_WIDTH-1:0] a_data_ff;
	logic               b_we_ff;
	logic               b_re_ff;
	logic [BAW-1:0]     b_addr_ff;
	logic [B_WIDTH-1:0] b_data_ff;

	// Queue and shift pointers
	logic [AAW-1:0]     wptr_ff;
	logic [AAW-1:0]     rptr_ff;
	logic [CW-1:0]      count_ff;
	logic [AAW-1:0]     nxt_wptr;
	logic [AAW-1:0]     nxt_rptr;
	logic [CW-1:0]      nxt_count;

	// Stored read words and output registers
	logic [A_WIDTH-1:0] a_raw;
	logic [B_WIDTH-1:0] b_raw;
	logic [A_WIDTH-1:0] a_out_ff;
	logic [B_WIDTH-1:0] b_out_ff;

	// Mode decode
	wire is_sdp   = (cfg.mode == edpr_pkg::EDPR_SIMPLE_DP);
	wire is_sp    = (cfg.mode == edpr_pkg::EDPR_SINGLE_PORT);
	wire is_tdp   = (cfg.mode == edpr_pkg::EDPR_TRUE_DP);
	wire is_rom   = (cfg.mode == edpr_pkg::EDPR_ROM);
	wire is_fifo  = (cfg.mode == edpr_pkg::EDPR_FIFO);
	wire is_shift = (cfg.mode == edpr_pkg::EDPR_SHIFT);
	wire is_small = (BLOCK_SIZE == edpr_pkg::EDPR_SMALL);
	wire is_large = (BLOCK_SIZE == edpr_pkg::EDPR_LARGE);

	// Mode and width legality for this size
	wire mode_ok  = !(is_small && is_tdp) &&
		!(is_large && (is_rom || is_shift));
	wire width_ok = !MIXED || is_sdp || is_rom || (is_tdp && !is_small);
	wire tdp_on   = is_tdp && !is_small;

	// Queue handshake
	wire push     = is_fifo && a_wren && !fifo_full_ff;
	wire pop      = is_fifo && b_rden && !fifo_empty_ff;
	wire shift_en = is_shift && a_wren;

	// Steering into the input registers
	wire            eff_a_we   = is_fifo ? push : (shift_en || (a_wren && !is_rom && !is_shift));
	wire            eff_a_re   = (is_sp || tdp_on) && a_rden;
	wire [AAW-1:0]  eff_a_addr = (is_fifo || is_shift) ? wptr_ff : a_addr;
	wire            eff_b_we   = tdp_on && b_wren;
	wire            eff_b_re   = is_fifo ? pop : (is_shift ? shift_en :
		((is_sdp || is_rom || is_tdp) && b_rden));
	wire [BAW-1:0]  eff_b_addr = is_fifo ? BAW'(rptr_ff) : (is_shift ? BAW'(wptr_ff) : b_addr);

	// Input registers, cleared at once by in_aclr
	always_ff @(posedge clk or posedge in_aclr) begin
		if (in_aclr) begin
			a_we_ff   <= `EDPR_CLEAR_VAL;
			a_re_ff   <= `EDPR_CLEAR_VAL;
			a_addr_ff <= '0;
			a_data_ff <= '0;
			b_we_ff   <= `EDPR_CLEAR_VAL;
			b_re_ff   <= `EDPR_CLEAR_VAL;
			b_addr_ff <= '0;
			b_data_ff <= '0;
		end else if (!reset_n) begin
			a_we_ff   <= `EDPR_CLEAR_VAL;
			a_re_ff   <= `EDPR_CLEAR_VAL;
			a_addr_ff <= '0;
			a_data_ff <= '0;
			b_we_ff   <= `EDPR_CLEAR_VAL;
			b_re_ff   <= `EDPR_CLEAR_VAL;
			b_addr_ff <= '0;
			b_data_ff <= '0;
		end else begin
			a_we_ff   <= eff_a_we;
			a_data_ff <= a_data;
			a_addr_ff <= eff_a_addr;
			a_re_ff   <= eff_a_re;
			b_we_ff   <= eff_b_we;
			b_re_ff   <= eff_b_re;
			b_addr_ff <= eff_b_addr;
			b_data_ff <= b_data;
		end
	end

	// Pointer and occupancy next values
	assign nxt_wptr  = (push || shift_en) ? wptr_ff + AAW'(1) : wptr_ff;
	assign nxt_rptr  = pop ? rptr_ff + AAW'(1) : rptr_ff;
	assign nxt_count = count_ff + CW'(push) - CW'(pop);

	always_ff @(posedge clk) begin
		if (!reset_n) begin
			wptr_ff       <= '0;
			rptr_ff       <= '0;
			count_ff      <= '0;
			fifo_full_ff  <= `EDPR_CLEAR_VAL;
			fifo_empty_ff <= `EDPR_EMPTY_VAL;
		end else begin
			wptr_ff       <= nxt_wptr;
			rptr_ff       <= nxt_rptr;
			count_ff      <= nxt_count;
			fifo_full_ff  <= (nxt_count == CW'(A_DEPTH));
			fifo_empty_ff <= (nxt_count == '0);
		end
	end

	// Shape, mode and width legality shown to the fabric
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			cfg_legal_ff <= `EDPR_CLEAR_VAL;
		end else begin
			cfg_legal_ff <= SHAPE_OK && mode_ok && width_ok;
		end
	end

	edpr_store #(
		.A_WIDTH    (A_WIDTH),
		.B_WIDTH    (B_WIDTH),
		.A_DEPTH    (A_DEPTH),
		.B_DEPTH    (B_DEPTH),
		.INIT_EN    (INIT_EN),
		.INIT_IMAGE (INIT_IMAGE)
	) u_store (
		.clk      (clk),
		.reset_n  (reset_n),
		.a_we     (a_we_ff),
		.a_re     (a_re_ff),
		.a_addr   (a_addr_ff),
		.a_wdata  (a_data_ff),
		.b_we     (b_we_ff),
		.b_re     (b_re_ff),
		.b_addr   (b_addr_ff),
		.b_wdata  (b_data_ff),
		.a_raw_ff (a_raw),
		.b_raw_ff (b_raw)
	);

	// Output registers, cleared at once by out_aclr
	always_ff @(posedge clk or posedge out_aclr) begin
		if (out_aclr) begin
			a_out_ff <= '0;
			b_out_ff <= '0;
		end else if (!reset_n) begin
			a_out_ff <= '0;
			b_out_ff <= '0;
		end else begin
			a_out_ff <= a_raw;
			b_out_ff <= b_raw;
		end
	end

	// Output register is the only bypassable stage
	assign a_q = cfg.out_bypass ? a_raw : a_out_ff;
	assign b_q = cfg.out_bypass ? b_raw : b_out_ff;

endmodule

/* File: sim/edpr_fabric.sv */
// Fabric-side model of the RAM block: write strobe, read strobe, addresses and data.
// Assumes the default 32x16 shape; every change lands on the falling edge.
`timescale 1ns/1ps
module edpr_fabric (
	input  wire logic        clk,
	output logic             a_wren,
	output logic             a_rden,
	output logic             b_rden,
	output logic      [4:0]  a_addr,
	output logic      [4:0]  b_addr,
	output logic      [15:0] a_data
);
	initial begin
		a_wren = 1'b0;
		a_rden = 1'b0;
		b_rden = 1'b0;
		a_addr = 5'h00;
		b_addr = 5'h00;
		a_data = 16'h0000;
	end
	// One request per falling edge; unused address and data lines toggle instead of holding
	task automatic cyc(input logic we, input logic re, input logic [4:0] wa,
		input logic [4:0] ra, input logic [15:0] d);
		@(negedge clk);
		a_wren = we;
		a_rden = 1'b0;
		b_rden = re;
		a_addr = we ? wa : ~a_addr;
		b_addr = re ? ra : ~b_addr;
		a_data = we ? d : ~a_data;
	endtask
	// Port A alone, as single-port user logic drives it
	task automatic acc_a(input logic we, input logic re, input logic [4:0] ad,
		input logic [15:0] d);
		@(negedge clk);
		a_wren = we;
		a_rden = re;
		b_rden = 1'b0;
		a_addr = ad;
		a_data = d;
	endtask
endmodule

/* File: sim/edpr_top_asserts.sv */
// Port checker of the RAM block: read latency, clears and shape flags.
// Assumes one clock; bound into every edpr_top instance.
`timescale 1ns/1ps
module edpr_top_asserts #(
	parameter edpr_pkg::edpr_size_e BLOCK_SIZE = edpr_pkg::EDPR_SMALL,
	parameter int                   A_WIDTH    = 16,
	parameter int                   B_WIDTH    = 16,
	parameter int                   A_DEPTH    = 32
) (
	input  wire logic                clk,
	input  wire logic                reset_n,
	input  wire logic                in_aclr,
	input  wire logic                out_aclr,
	input  wire edpr_pkg::edpr_cfg_s cfg,
	input  wire logic                b_rden,
	input  wire logic [A_WIDTH-1:0]  a_q,
	input  wire logic [B_WIDTH-1:0]  b_q,
	input  wire logic                fifo_full_ff,
	input  wire logic                fifo_empty_ff,
	input  wire logic                cfg_legal_ff
);
	localparam bit SHAPE_OK = (A_WIDTH == 9) ? (A_DEPTH == 64) :
		(A_WIDTH * A_DEPTH == 512 && A_WIDTH inside {1, 2, 4, 8, 16});
	logic [1:0]          quiet_ff;
	edpr_pkg::edpr_cfg_s prev_cfg_ff;
	wire logic           is_small = (BLOCK_SIZE == edpr_pkg::EDPR_SMALL);
	wire logic           is_tdp   = (cfg.mode == edpr_pkg::EDPR_TRUE_DP);
	wire logic           is_fifo  = (cfg.mode == edpr_pkg::EDPR_FIFO);
	wire logic           rd_mode  = is_fifo || cfg.mode inside {edpr_pkg::EDPR_SIMPLE_DP,
		edpr_pkg::EDPR_ROM};
	// Cycles since reset, output clear or a new configuration
	always_ff @(posedge clk) begin
		prev_cfg_ff <= cfg;
		if (!reset_n || out_aclr || cfg != prev_cfg_ff) begin
			quiet_ff <= 2'h0;
		end else if (quiet_ff != 2'h3) begin
			quiet_ff <= quiet_ff + 2'h1;
		end
	end
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!reset_n);
	chk_rd_latency: assert property (quiet_ff == 2'h3 && rd_mode && !cfg.out_bypass
		&& !out_aclr && $stable(cfg) && $changed(b_q) |-> $past(b_rden, 3))
		else $error("b_q changed without a read three cycles before");
	chk_byp_latency: assert property (quiet_ff == 2'h3 && rd_mode && cfg.out_bypass
		&& $stable(cfg) && $changed(b_q) |-> $past(b_rden, 2))
		else $error("bypassed b_q changed without a read two cycles before");
	chk_out_clear_now: assert property (out_aclr && !cfg.out_bypass |-> b_q == '0)
		else $error("output clear not seen on b_q at once");
	chk_out_clear_a: assert property (out_aclr && !cfg.out_bypass |-> a_q == '0)
		else $error("output clear not seen on a_q at once");
	chk_in_clear_hold: assert property (in_aclr && cfg.out_bypass && !out_aclr
		|=> !$stable(cfg) || $stable(b_q))
		else $error("read word changed after input clear");
	chk_small_no_tdp: assert property (quiet_ff >= 2'h2 && is_small && is_tdp
		&& $stable(cfg) |-> !cfg_legal_ff)
		else $error("true dual-port accepted on the small block");
	chk_shape_legal: assert property (quiet_ff >= 2'h2 && is_small && !is_tdp
		&& $stable(cfg) |-> cfg_legal_ff == SHAPE_OK)
		else $error("cfg_legal_ff disagrees with the shape");
	chk_flags_excl: assert property (!(fifo_full_ff && fifo_empty_ff))
		else $error("fifo full and empty together");
	chk_full_holds: assert property (is_fifo && fifo_full_ff && !b_rden && $stable(cfg)
		|=> fifo_full_ff || !$stable(cfg))
		else $error("full flag dropped without a pop");
	cov_full: cover property (is_fifo && fifo_full_ff);
	cov_out_clear: cover property (out_aclr && !cfg.out_bypass);
	cov_in_clear: cover property (in_aclr && cfg.out_bypass);
endmodule

bind edpr_top edpr_top_asserts #(.BLOCK_SIZE(BLOCK_SIZE), .A_WIDTH(A_WIDTH), .B_WIDTH(B_WIDTH),
	.A_DEPTH(A_DEPTH)) u_chk (.clk, .reset_n, .in_aclr, .out_aclr, .cfg, .b_rden, .a_q, .b_q,
	.fifo_full_ff, .fifo_empty_ff, .cfg_legal_ff);

/* File: sim/edpr_top_tb.sv */
// Testbench of the RAM block in the small 32x16 shape, fabric model on the ports.
// Assumes the design, the fabric model and the checker are compiled first.
`timescale 1ns/1ps
module edpr_top_tb;
	logic                clk      = 1'b0;
	logic                reset_n  = 1'b0;
	logic                in_aclr  = 1'b0;
	logic                out_aclr = 1'b0;
	edpr_pkg::edpr_cfg_s cfg      = '{edpr_pkg::EDPR_SIMPLE_DP, 1'b0};
	logic                a_wren, a_rden, b_rden, full, empty, legal;
	logic [4:0]          a_addr, b_addr;
	logic [15:0]         a_data, a_q, b_q;
	int                  n_mismatch = 0;
	int                  n_tests    = 0;
	always #5 clk = ~clk;
	function automatic logic [511:0] img();
		for (int k = 0; k < 32; k++) begin
			img[16*k +: 16] = 16'hA500 + 16'(k);
		end
	endfunction
	edpr_top #(.INIT_IMAGE(img())) dut (.clk(clk), .reset_n(reset_n), .in_aclr(in_aclr),
		.out_aclr(out_aclr), .cfg(cfg), .a_wren(a_wren), .a_rden(a_rden), .a_addr(a_addr),
		.a_data(a_data), .b_wren(1'b0), .b_rden(b_rden), .b_addr(b_addr), .b_data(16'h0000),
		.a_q(a_q), .b_q(b_q), .fifo_full_ff(full), .fifo_empty_ff(empty), .cfg_legal_ff(legal));
	edpr_fabric fab (.clk(clk), .a_wren(a_wren), .a_rden(a_rden), .b_rden(b_rden),
		.a_addr(a_addr), .b_addr(b_addr), .a_data(a_data));
	task automatic cmp(input string what, input logic [15:0] exp, input logic [15:0] got);
		n_tests++;
		if (got !== exp) begin
			n_mismatch++;
			$display("ERROR %s expected %h seen %h", what, exp, got);
		end
	endtask
	// One read, then idle until the word is due
	task automatic rd(input logic [4:0] ad, input int lat);
		fab.cyc(1'b0, 1'b1, 5'h00, ad, 16'h0000);
		fab.cyc(1'b0, 1'b0, 5'h00, 5'h00, 16'h0000);
		repeat (lat) @(negedge clk);
	endtask
	task automatic t_modes();
		for (int m = 0; m < 6; m++) begin
			cfg.mode = edpr_pkg::edpr_mode_e'(m);
			repeat (4) @(negedge clk);
			cmp("cfg_legal_ff", {15'h0, cfg.mode != edpr_pkg::EDPR_TRUE_DP}, {15'h0, legal});
		end
		cfg.mode = edpr_pkg::EDPR_SIMPLE_DP;
	endtask
	task automatic t_ram();
		rd(5'h03, 2);
		cmp("preload", 16'hA503, b_q);
		fab.cyc(1'b1, 1'b1, 5'h05, 5'h05, 16'h1234);
		fab.cyc(1'b0, 1'b0, 5'h00, 5'h00, 16'h0000);
		repeat (2) @(negedge clk);
		cmp("collision", 16'hA505, b_q);
		rd(5'h05, 2);
		cmp("write_back", 16'h1234, b_q);
		cfg.out_bypass = 1'b1;
		rd(5'h03, 1);
		cmp("bypass", 16'hA503, b_q);
		fab.cyc(1'b0, 1'b1, 5'h00, 5'h05, 16'h0000);
		fab.cyc(1'b0, 1'b0, 5'h00, 5'h00, 16'h0000);
		in_aclr = 1'b1;
		@(negedge clk);
		in_aclr = 1'b0;
		@(negedge clk);
		cmp("in_clear", 16'hA503, b_q);
		cfg.out_bypass = 1'b0;
		out_aclr = 1'b1;
		#1;
		cmp("out_clear", 16'h0000, b_q);
		@(negedge clk);
		out_aclr = 1'b0;
		cfg.mode = edpr_pkg::EDPR_ROM;
		fab.cyc(1'b1, 1'b0, 5'h07, 5'h00, 16'hBEEF);
		rd(5'h07, 2);
		cmp("rom_write", 16'hA507, b_q);
	endtask
	task automatic t_fifo();
		cfg.mode = edpr_pkg::EDPR_FIFO;
		for (int i = 0; i < 33; i++) begin
			fab.cyc(1'b1, 1'b0, 5'h00, 5'h00, 16'h5A00 + 16'(i));
		end
		fab.cyc(1'b0, 1'b0, 5'h00, 5'h00, 16'h0000);
		cmp("full", 16'h0001, {15'h0, full});
		for (int i = 0; i < 33; i++) begin
			rd(5'h00, 2);
			cmp("pop", 16'h5A00 + 16'((i < 32) ? i : 31), b_q);
		end
		cmp("empty", 16'h0001, {15'h0, empty});
	endtask
	// Thirty-three shifts: the last one returns the first word shifted in
	task automatic t_shift();
		cfg.mode = edpr_pkg::EDPR_SHIFT;
		for (int i = 0; i < 33; i++) begin
			fab.cyc(1'b1, 1'b0, 5'h00, 5'h00, 16'h3C00 + 16'(i));
		end
		fab.cyc(1'b0, 1'b0, 5'h00, 5'h00, 16'h0000);
		repeat (2) @(negedge clk);
		cmp("shift_out", 16'h3C00, b_q);
	endtask
	// Port A write then read back on a_q, then output clear on a_q
	task automatic t_single();
		cfg.mode = edpr_pkg::EDPR_SINGLE_PORT;
		fab.acc_a(1'b1, 1'b0, 5'h0A, 16'hC0DE);
		fab.acc_a(1'b0, 1'b1, 5'h0A, 16'h0000);
		fab.acc_a(1'b0, 1'b0, 5'h00, 16'h0000);
		repeat (2) @(negedge clk);
		cmp("single_port", 16'hC0DE, a_q);
		out_aclr = 1'b1;
		#1;
		cmp("out_clear_a", 16'h0000, a_q);
		@(negedge clk);
		out_aclr = 1'b0;
	endtask
	task automatic print_verdict();
		if (n_mismatch == 0 && n_tests > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask
	initial begin
		repeat (8) @(negedge clk);
		reset_n = 1'b1;
		cmp("reset_empty", 16'h0001, {15'h0, empty});
		t_modes();
		t_ram();
		t_fifo();
		t_shift();
		t_single();
		print_verdict();
	end
endmodule
